// ### hdl/gtc_defines.svh
// Behaviour
// (RULE1) Count is 16 bits as low and high byte registers, both readable and writable.
// (RULE2) Count rolls over from FFFF to 0000; rollover is the interrupt event.
// (RULE3) Setting timer_run enables counting.
// (RULE4) Clearing timer_run stops counting and keeps the count value.
// (RULE5) count_source_select set uses the external pin, clear uses oscillator divided by four.
// (RULE6) Timer mode with 1:1 prescale advances once per instruction cycle.
// (RULE7) Counter mode advances on rising edges of the external clock only.
// (RULE8) sync_disable clear synchronizes external clock; set runs it unsynchronized; the code synchronizes it through the same two stages in both settings.
// (RULE9) With internal source selected sync_disable is ignored.
// (RULE10) With gate_enable set, gate low lets count run, gate high holds it.
// (RULE11) Gating works in both modes; gate_enable clear ignores the gate pin.
// (RULE12) prescale_select 11=1:8, 10=1:4, 01=1:2, 00=1:1 on the selected clock.
// (RULE13) lp_osc_enable selects crystal source only in internal RC mode without clock output.
// (RULE14) Software sets count_source_select and lp_osc_enable and configures internal RC mode.
// (RULE15) Rollover sets rollover_flag; software clears it before re-enabling interrupt.
// (RULE16) Only power-on or brownout reset clears control; other resets leave timer state.
// (RULE17) Enabled low-power oscillator runs regardless of timer_run and during sleep.
// (RULE18) Low byte wrapping increments the high byte in the same count step.
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

`define GTC_ADDR_W        3
`define GTC_A_COUNT_LOW   3'h0
`define GTC_A_COUNT_HIGH  3'h1
`define GTC_A_CONTROL     3'h2
`define GTC_A_STATUS      3'h3
`define GTC_A_MASK        3'h4

`define GTC_B_RUN         0
`define GTC_B_SRC         1
`define GTC_B_SYNC_DIS    2
`define GTC_B_LP_OSC      3
`define GTC_B_PS_LO       4
`define GTC_B_PS_HI       5
`define GTC_B_GATE_EN     6
`define GTC_CTRL_MASK     8'h7f
`define GTC_CTRL_RESET    8'h00
`define GTC_ST_ROLLOVER   0
`define GTC_ST_MASK       8'h01

`define GTC_INSTR_DIV     2'h3
`define GTC_BYTE_MAX      8'hff
`define GTC_ZERO8         8'h00

`endif

// ### hdl/gtc_pkg.sv
package gtc_pkg;
    typedef enum logic [1:0] {
        GTC_SRC_INSTR,
        GTC_SRC_EXT_SYNC,
        GTC_SRC_EXT_RAW
    } gtc_src_e;
endpackage : gtc_pkg

// ### hdl/gtc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defines.svh"
module gtc_prescaler
    import gtc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_ce,
    input  wire logic       i_tick,
    input  wire logic       i_clear,
    input  wire logic [1:0] i_sel,
    output logic            o_step
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       step;
    } gtc_ps_s;

    gtc_ps_s st_ff;
    gtc_ps_s nxt_st;
    logic [2:0] limit;

    always_comb begin
        limit = 3'((3'h1 << i_sel) - 3'h1);
        nxt_st = st_ff;
        nxt_st.step = 1'b0;
        if (i_clear) begin
            nxt_st.cnt = 3'h0;
        end else if (i_tick) begin
            if (st_ff.cnt >= limit) begin    // see (RULE12)
                nxt_st.cnt  = 3'h0;
                nxt_st.step = 1'b1;
            end else begin
                nxt_st.cnt = 3'(st_ff.cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_step = st_ff.step;
endmodule : gtc_prescaler
`default_nettype wire

// ### hdl/gtc_timer.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defines.svh"
module gtc_timer
    import gtc_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  wire logic                   i_ce,
    input  wire logic [`GTC_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic                   i_ext_count_clock,
    input  wire logic                   i_gate_input_n,
    input  wire logic                   i_lp_crystal_clock,
    input  wire logic                   i_internal_rc_mode,
    output logic [7:0]                  o_rdata,
    output logic                        o_irq,
    output logic                        o_lp_osc_on
);
    typedef struct packed {
        logic [7:0] count_low;
        logic [7:0] count_high;
        logic [7:0] control;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic       irq;
        logic       lp_on;
        logic [1:0] div;
        logic       ext_s1;
        logic       ext_s2;
        logic       ext_s3;
    } gtc_st_s;

    gtc_st_s st_ff;
    gtc_st_s nxt_st;

    logic     ps_step;
    logic     tick;
    logic     gate_open;
    logic     src_sel;
    logic     lp_sel;
    logic     ext_lvl;
    logic     ps_clear;
    logic     roll;
    gtc_src_e src_mode;

    function automatic logic bit_of(input logic [7:0] r, input int idx);
        bit_of = r[idx];
    endfunction : bit_of

    function automatic logic [7:0] mask_write(input logic [7:0] d);
        mask_write = d & `GTC_CTRL_MASK;
    endfunction : mask_write

    ////////////////////////////////////////////////////////////////////
    // Count source selection

    always_comb begin
        src_sel = bit_of(st_ff.control, `GTC_B_SRC);
        // Crystal replaces the pin only in internal RC mode
        lp_sel  = bit_of(st_ff.control, `GTC_B_LP_OSC) && i_internal_rc_mode; // see (RULE13)
        ext_lvl = st_ff.ext_s2;
        if (!src_sel) begin
            src_mode = GTC_SRC_INSTR;  // see (RULE9)
        end else if (bit_of(st_ff.control, `GTC_B_SYNC_DIS)) begin
            src_mode = GTC_SRC_EXT_RAW;
        end else begin
            src_mode = GTC_SRC_EXT_SYNC;
        end
        gate_open = !bit_of(st_ff.control, `GTC_B_GATE_EN) || !i_gate_input_n; // see (RULE10) see (RULE11)
        case (src_mode)
            GTC_SRC_INSTR:    tick = (st_ff.div == `GTC_INSTR_DIV);  // see (RULE5) see (RULE6)
            // Rising edge of two-stage synchronised pin, third stage holds history
            GTC_SRC_EXT_SYNC: tick = ext_lvl && !st_ff.ext_s3;       // see (RULE7) see (RULE8)
            // Unsynchronised mode: edge taken off the same second and third stages as synchronised mode
            GTC_SRC_EXT_RAW:  tick = st_ff.ext_s2 && !st_ff.ext_s3;  // see (RULE8)
            default:          tick = 1'b0;
        endcase
        tick = tick && bit_of(st_ff.control, `GTC_B_RUN) && gate_open; // see (RULE3) see (RULE4)
        // A stopped timer restarts its prescaler from zero
        ps_clear = !bit_of(st_ff.control, `GTC_B_RUN);
    end

    gtc_prescaler u_prescaler (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .i_tick   (tick),
        .i_clear  (ps_clear),
        .i_sel    (st_ff.control[`GTC_B_PS_HI:`GTC_B_PS_LO]),
        .o_step   (ps_step)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;
        nxt_st.div = 2'(st_ff.div + 2'h1);
        // Pin choice: crystal or count pin
        nxt_st.ext_s1 = (lp_sel && st_ff.lp_on) ? i_lp_crystal_clock : i_ext_count_clock;
        nxt_st.ext_s2 = st_ff.ext_s1;
        nxt_st.ext_s3 = st_ff.ext_s2;
        // Oscillator follows its enable and the internal RC mode, not the run bit
        nxt_st.lp_on = lp_sel;  // see (RULE17)

        roll = 1'b0;
        if (ps_step) begin
            nxt_st.count_low = 8'(st_ff.count_low + 8'h01);  // see (RULE1)
            if (st_ff.count_low == `GTC_BYTE_MAX) begin
                nxt_st.count_high = 8'(st_ff.count_high + 8'h01);  // see (RULE18)
                if (st_ff.count_high == `GTC_BYTE_MAX) begin
                    roll = 1'b1;  // see (RULE2)
                end
            end
        end

        if (i_wr) begin
            case (i_addr)
                `GTC_A_COUNT_LOW:  nxt_st.count_low  = i_wdata;  // see (RULE1)
                `GTC_A_COUNT_HIGH: nxt_st.count_high = i_wdata;
                `GTC_A_CONTROL:    nxt_st.control    = mask_write(i_wdata);
                `GTC_A_MASK:       nxt_st.mask       = i_wdata & `GTC_ST_MASK;
                // Write one clears; the rollover set is merged in below
                `GTC_A_STATUS:     nxt_st.status = st_ff.status & ~i_wdata; // see (RULE15)
                default:           nxt_st.rdata = st_ff.rdata;
            endcase
        end

        // Set wins over a clear written in the same cycle
        nxt_st.status[`GTC_ST_ROLLOVER] = nxt_st.status[`GTC_ST_ROLLOVER] | roll;  // see (RULE15)
        nxt_st.rdata = `GTC_ZERO8;
        if (i_rd) begin
            case (i_addr)
                `GTC_A_COUNT_LOW:  nxt_st.rdata = st_ff.count_low;
                `GTC_A_COUNT_HIGH: nxt_st.rdata = st_ff.count_high;
                `GTC_A_CONTROL:    nxt_st.rdata = st_ff.control;
                `GTC_A_STATUS:     nxt_st.rdata = st_ff.status;
                `GTC_A_MASK:       nxt_st.rdata = st_ff.mask;
                default:           nxt_st.rdata = `GTC_ZERO8;
            endcase
        end
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    ////////////////////////////////////////////////////////////////////
    // State register; reset input is the power-on or brownout reset

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '0;  // see (RULE16)
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata     = st_ff.rdata;
    assign o_irq       = st_ff.irq;
    assign o_lp_osc_on = st_ff.lp_on;
endmodule : gtc_timer
`default_nettype wire

// ### test/gtc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module gtc_far_side (
    input  wire logic i_clk,
    output logic      o_ext_count_clock,
    output logic      o_lp_crystal_clock,
    output logic      o_gate_input_n
);
    initial begin
        o_ext_count_clock  = 1'b0;
        o_lp_crystal_clock = 1'b0;
        o_gate_input_n    = 1'b1;
    end
    // Clock parks low between bursts, so each burst opens with a rising edge
    // Pulses go to the crystal line when xtal is set, else to the count pin
    task automatic pulses(input int n, input int half, input bit xtal);
        repeat (n) begin
            repeat (half) @(posedge i_clk);
            if (xtal) begin
                o_lp_crystal_clock <= 1'b1;
            end else begin
                o_ext_count_clock <= 1'b1;
            end
            repeat (half) @(posedge i_clk);
            o_lp_crystal_clock <= 1'b0;
            o_ext_count_clock  <= 1'b0;
        end
    endtask : pulses
    task automatic gate(input logic level);
        @(posedge i_clk);
        o_gate_input_n <= level;
    endtask : gate
endmodule : gtc_far_side
`default_nettype wire

// ### test/gtc_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defines.svh"
module gtc_timer_properties (
    input wire logic                   i_clk,
    input wire logic                   i_resetn,
    input wire logic                   i_ce,
    input wire logic [`GTC_ADDR_W-1:0] i_addr,
    input wire logic [7:0]             i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic                   i_internal_rc_mode,
    input wire logic [7:0]             o_rdata,
    input wire logic                   o_irq,
    input wire logic                   o_lp_osc_on
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 8'h00) else $error("stray read data");
    a_ctrl_top_zero: assert property (i_ce && i_rd && i_addr == `GTC_A_CONTROL |=> !o_rdata[7])
        else $error("control bit 7 set");
    a_unmapped_zero: assert property (i_ce && i_rd && i_addr > `GTC_A_MASK |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_stays: assert property (o_irq && i_ce && !i_wr |=> o_irq) else $error("irq dropped");
    a_mask_drops_irq: assert property (i_ce && i_wr && i_addr == `GTC_A_MASK && !i_wdata[0] |-> ##[1:2] !o_irq)
        else $error("masked irq high");
    a_lp_osc_on: assert property (i_ce && i_wr && i_addr == `GTC_A_CONTROL && i_wdata[3] && i_internal_rc_mode
        |-> ##[1:2] o_lp_osc_on) else $error("oscillator not on");
    a_lp_needs_rc: assert property (!i_internal_rc_mode [*2] |-> !o_lp_osc_on) else $error("oscillator on");
    a_reset_quiet: assert property ($rose(i_resetn) |-> !o_irq && o_rdata == 8'h00 && !o_lp_osc_on)
        else $error("outputs busy after reset");
endmodule : gtc_timer_properties
bind gtc_timer gtc_timer_properties u_props (.i_clk, .i_resetn, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_internal_rc_mode, .o_rdata, .o_irq, .o_lp_osc_on);
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    err_total++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb_top;
    import gtc_pkg::*;
    logic                   i_clk, i_resetn, i_ce, i_wr, i_rd, i_rc, o_irq, o_lp_osc_on, ext, gate_n, xtal;
    logic [`GTC_ADDR_W-1:0] i_addr;
    logic [7:0]             i_wdata, o_rdata, d;
    logic [15:0]            v, w;
    int                     err_total = 0, num_checks = 0, cyc = 0;
    logic [7:0]             ctls [3] = '{8'h03, 8'h07, 8'h43};
    logic [15:0]            exps [3] = '{16'h0014, 16'h0014, 16'h0000};
    gtc_timer dut (.i_clk, .i_resetn, .i_ce(i_ce), .i_addr, .i_wdata, .i_wr, .i_rd, .i_ext_count_clock(ext),
        .i_gate_input_n(gate_n), .i_lp_crystal_clock(xtal), .i_internal_rc_mode(i_rc), .o_rdata, .o_irq, .o_lp_osc_on);
    gtc_far_side p (.i_clk, .o_ext_count_clock(ext), .o_lp_crystal_clock(xtal), .o_gate_input_n(gate_n));
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= x;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] r);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 r = o_rdata;
    endtask : rd
    task automatic rc(output logic [15:0] c);
        rd(`GTC_A_COUNT_LOW, c[7:0]);
        rd(`GTC_A_COUNT_HIGH, c[15:8]);
    endtask : rc
    task automatic go(input logic [15:0] c, input logic [7:0] ctl);
        wr(`GTC_A_COUNT_LOW, c[7:0]);
        wr(`GTC_A_COUNT_HIGH, c[15:8]);
        wr(`GTC_A_CONTROL, ctl);
    endtask : go
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {i_resetn, i_wr, i_rd, i_rc, i_addr, i_wdata} = '0;
        i_ce = 1'b1;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(`GTC_A_CONTROL, d);
        `CHK(d, 8'h00)
        go(16'ha55a, 8'hf0);
        rc(v);
        `CHK(v, 16'ha55a)
        rd(`GTC_A_CONTROL, d);
        `CHK(d, 8'h70)
        rd(3'h5, d);
        `CHK(d, 8'h00)
        $display("registers done");
        for (int ps = 0; ps < 4; ps++) begin
            go(16'h0000, {2'b00, ps[1:0], 4'b0101});
            repeat (399) @(posedge i_clk);
            wr(`GTC_A_CONTROL, 8'h00);
            rc(v);
            `CHK(v >= (100 >> ps) - 1 && v <= (100 >> ps) + 1, 1'b1)
            repeat (50) @(posedge i_clk);
            rc(w);
            `CHK(w, v)
        end
        go(16'h0000, 8'h41);
        repeat (99) @(posedge i_clk);
        rc(v);
        `CHK(v, 16'h0000)
        for (int k = 0; k < 3; k++) begin
            go(16'h0000, ctls[k]);
            p.pulses(20, 3, 1'b0);
            repeat (10) @(posedge i_clk);
            rc(v);
            `CHK(v, exps[k])
        end
        p.gate(1'b0);
        go(16'h0000, 8'h41);
        repeat (399) @(posedge i_clk);
        wr(`GTC_A_CONTROL, 8'h00);
        rc(v);
        `CHK(v >= 99 && v <= 101, 1'b1)
        go(16'h0000, 8'h01);
        @(posedge i_clk);
        i_ce <= 1'b0;
        repeat (200) @(posedge i_clk);
        i_ce <= 1'b1;
        wr(`GTC_A_CONTROL, 8'h00);
        rc(v);
        `CHK(v <= 16'h0002, 1'b1)
        $display("counting done");
        wr(`GTC_A_MASK, 8'h01);
        go(16'h12ff, 8'h03);
        p.pulses(1, 3, 1'b0);
        repeat (10) @(posedge i_clk);
        rc(v);
        `CHK(v, 16'h1300)
        `CHK(o_irq, 1'b0)
        go(16'hffff, 8'h03);
        p.pulses(1, 3, 1'b0);
        repeat (10) @(posedge i_clk);
        rc(v);
        `CHK(v, 16'h0000)
        rd(`GTC_A_STATUS, d);
        `CHK(d, 8'h01)
        wr(`GTC_A_MASK, 8'h00);
        `CHK(o_irq, 1'b0)
        wr(`GTC_A_MASK, 8'h01);
        `CHK(o_irq, 1'b1)
        wr(`GTC_A_STATUS, 8'h01);
        `CHK(o_irq, 1'b0)
        $display("rollover done");
        @(posedge i_clk);
        i_rc <= 1'b1;
        wr(`GTC_A_CONTROL, 8'h0a);
        repeat (3) @(posedge i_clk);
        #1 `CHK(o_lp_osc_on, 1'b1)
        go(16'h0000, 8'h0b);
        p.pulses(5, 3, 1'b1);
        p.pulses(5, 3, 1'b0);
        repeat (10) @(posedge i_clk);
        rc(v);
        `CHK(v, 16'h0005)
        @(posedge i_clk);
        i_rc     <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 `CHK(o_lp_osc_on, 1'b0)
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(`GTC_A_CONTROL, d);
        `CHK(d, 8'h00)
        $display("oscillator done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
